/* File: rtl/rscd_defs.svh */
// constants for the radio serial control decode block
`ifndef RSCD_DEFS_SVH
`define RSCD_DEFS_SVH
// word lengths: word one 23 bits, word two 11 bits, address bit last
`define RSCD_W1_LEN       23
`define RSCD_W2_LEN       11
// address bit values
`define RSCD_SEL_W1       1'b1
`define RSCD_SEL_W2       1'b0
// word one field positions
`define RSCD_RC_LSB       21
`define RSCD_SC_LSB       16
`define RSCD_MC_LSB       14
`define RSCD_OSC_BIT      13
`define RSCD_TEST_BIT     11
`define RSCD_GF_BIT       10
`define RSCD_MCC_BIT      9
`define RSCD_DEV_LSB      6
`define RSCD_PRE_LSB      3
`define RSCD_CPT_LSB      0
// word two field positions
`define RSCD_DEMOD_LSB    6
`define RSCD_MOD_COMP_SCALE_LSB     3
`define RSCD_TSEL_LSB     0
// reset values
`define RSCD_W1_RESET     23'h000000
`define RSCD_W2_RESET     11'h000
// main divider base ratio and ref divider ratios
`define RSCD_MAIN_BASE    6'h20
`define RSCD_REF_R0       4'h3
`define RSCD_REF_R1       4'h4
`define RSCD_REF_R2       4'h6
// reference/512 test divider width
`define RSCD_TDIV_W       9
// percent scale base and step
`define RSCD_PCT_BASE     8'h3C
`define RSCD_PCT_STEP     8'h0A
`endif

/* File: rtl/rscd_pkg.sv */
// types for the radio serial control decode block
package rscd_pkg;
   // word one fields
   typedef struct packed {
      logic [1:0] ref_divider_code;
      logic [4:0] swallow_count;
      logic [1:0] main_divider_code;
      logic       osc_select;
      logic       spare12;
      logic       test_bit;
      logic       gauss_filter_enable;
      logic       mod_comp_enable;
      logic [2:0] deviation_scale;
      logic [2:0] osc_pretune_code;
      logic [2:0] pump_current_trim;
   } rscd_word1_t;
   // word two fields
   typedef struct packed {
      logic [4:0] demod_center_trim;
      logic [2:0] mod_comp_scale;
      logic [2:0] test_select;
   } rscd_word2_t;
   // block enables
   typedef struct packed {
      logic tx_driver;
      logic ramp_gen;
      logic baseband_filter;
      logic demod;
      logic if_amp;
      logic ir_mixer;
      logic rx_switch;
      logic tx_switch;
      logic gauss_filter;
      logic mod_comp;
      logic program_divider;
      logic phase_compare;
      logic charge_pump;
      logic ref_divider;
      logic aux_reg;
      logic osc_reg;
   } rscd_enables_t;
   // operating mode
   typedef enum logic [1:0] {RSCD_IDLE, RSCD_TX, RSCD_RX, RSCD_RSSI} rscd_mode_t;
   // serial capture state
   typedef enum logic {RSCD_WAIT, RSCD_SHIFT} rscd_sstate_t;
endpackage : rscd_pkg

/* File: rtl/rscd_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`include "rscd_defs.svh"
module rscd_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // raw and filtered levels
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   // stage registers
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } rscd_sync_t;
   rscd_sync_t st;
   rscd_sync_t next_st;
   // width check
   initial begin
      if (WIDTH < 1) $error("width must be positive");
   end
   // next state: output moves only when stages two and three agree
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) next_st.q[i] = st.s3[i];
      end
   end
   // register all stages
   always_ff @(posedge clk or posedge reset) begin
      if (reset) st <= '0;
      else st <= next_st;
   end
   assign dout = st.q;
endmodule : rscd_sync

/* File: rtl/rscd_top.sv */
// three-wire programming port with latched words and mode decode
`timescale 1ns/1ps
`include "rscd_defs.svh"
module rscd_top #(
   parameter int W1_LEN = `RSCD_W1_LEN,
   parameter int W2_LEN = `RSCD_W2_LEN
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // three-wire bus pins
   input  wire logic                 bus_clock,
   input  wire logic                 bus_data,
   input  wire logic                 bus_enable,
   // mode and power-up pins
   input  wire logic                 rx_on,
   input  wire logic                 tx_on,
   input  wire logic                 aux_regulator_powerup,
   input  wire logic                 osc_regulator_powerup,
   input  wire logic                 radio_path_powerup,
   input  wire logic                 synth_powerup,
   input  wire logic                 pump_current_select,
   // synthesizer status and divider outputs
   input  wire logic                 synth_locked,
   input  wire logic                 ref_div_out,
   input  wire logic                 prog_div_out,
   // latched words
   output rscd_pkg::rscd_word1_t     channel_setup_word,
   output rscd_pkg::rscd_word2_t     production_trim_word,
   // decoded settings
   output logic [3:0]                ref_ratio,
   output logic [5:0]                main_ratio,
   output logic [4:0]                swallow_count,
   output logic                      osc_select,
   output logic [7:0]                deviation_pct,
   output logic [7:0]                mod_comp_pct,
   output logic [2:0]                osc_pretune_code,
   output logic signed [3:0]         pump_current_step,
   output logic [4:0]                demod_center_trim,
   output logic                      pump_high_current,
   output logic                      pump_high_z,
   // block enables and mode
   output rscd_pkg::rscd_enables_t   enables,
   output rscd_pkg::rscd_mode_t      mode,
   // lock pin
   output logic                      lock_indicator
);
   // width check
   initial begin
      if (W1_LEN != `RSCD_W1_LEN || W2_LEN != `RSCD_W2_LEN) $error("word lengths fixed by field layout");
   end
   // synchronised pin levels
   logic [10:0] pins_s;
   logic        sclk_s, sdat_s, sen_s, rxon_s, txon_s;
   logic        pu_aux_s, pu_osc_s, pu_radio_s, pu_synth_s, pump_sel_s, lock_s;
   rscd_sync #(.WIDTH(11)) u_sync (
      .clk   (clk),
      .reset (reset),
      .din   ({bus_clock, bus_data, bus_enable, rx_on, tx_on, aux_regulator_powerup,
               osc_regulator_powerup, radio_path_powerup, synth_powerup, pump_current_select, synth_locked}),
      .dout  (pins_s)
   );
   // unpack in the same order as packed above
   assign {sclk_s, sdat_s, sen_s, rxon_s, txon_s, pu_aux_s, pu_osc_s, pu_radio_s, pu_synth_s,
           pump_sel_s, lock_s} = pins_s;
   // ratio lookup for reference divider
   function automatic logic [3:0] rscd_ref_ratio(input logic [1:0] code);
      case (code)
         2'h0:    rscd_ref_ratio = `RSCD_REF_R0;
         2'h1:    rscd_ref_ratio = `RSCD_REF_R1;
         2'h2:    rscd_ref_ratio = `RSCD_REF_R2;
         default: rscd_ref_ratio = 4'h0;
      endcase
   endfunction : rscd_ref_ratio
   // percent scale lookup, used for deviation and compensation
   function automatic logic [7:0] rscd_pct(input logic [2:0] code);
      rscd_pct = 8'(`RSCD_PCT_BASE + 8'(code) * `RSCD_PCT_STEP);
   endfunction : rscd_pct
   // all block state
   typedef struct packed {
      rscd_pkg::rscd_sstate_t  sst;
      logic [W1_LEN:0]         shreg;
      logic                    sclk_d;
      logic                    sen_d;
      logic                    ref_d;
      logic                    prog_d;
      logic                    ref_half;
      logic                    prog_half;
      logic [`RSCD_TDIV_W-1:0] ref_cnt;
      rscd_pkg::rscd_word1_t   w1;
      rscd_pkg::rscd_word2_t   w2;
      logic [3:0]              ref_ratio;
      logic [5:0]              main_ratio;
      logic [7:0]              dev_pct;
      logic [7:0]              mcc_pct;
      logic signed [3:0]       cp_step;
      logic                    pump_hi;
      logic                    pump_z;
      rscd_pkg::rscd_enables_t en;
      rscd_pkg::rscd_mode_t    mode;
      logic [4:0]              demod_trim;
      logic                    lock_pin;
   } rscd_state_t;
   // registered state and its next value
   rscd_state_t st;
   rscd_state_t next_st;
   // transmit and receive qualifiers, radio path powered only
   logic tx_mode, rx_mode;
   // next state
   always_comb begin
      next_st        = st;
      next_st.sclk_d = sclk_s;
      next_st.sen_d  = sen_s;
      next_st.ref_d  = ref_div_out;
      next_st.prog_d = prog_div_out;
      tx_mode = 1'b0;
      rx_mode = 1'b0;
      // serial capture
      case (st.sst)
         rscd_pkg::RSCD_WAIT: begin
            // open a frame only on a falling enable, never on the reset level
            if (!sen_s && st.sen_d) next_st.sst = rscd_pkg::RSCD_SHIFT;
         end
         rscd_pkg::RSCD_SHIFT: begin
            if (!sen_s && sclk_s && !st.sclk_d) begin
               next_st.shreg = {st.shreg[W1_LEN-1:0], sdat_s};
            end
            if (sen_s) begin
               next_st.sst = rscd_pkg::RSCD_WAIT;
               if (st.shreg[0] == `RSCD_SEL_W1) next_st.w1 = st.shreg[W1_LEN:1];
               else next_st.w2 = st.shreg[W2_LEN:1];
            end
         end
         default: next_st.sst = rscd_pkg::RSCD_WAIT;
      endcase
      next_st.ref_ratio  = rscd_ref_ratio(st.w1.ref_divider_code);
      next_st.main_ratio = `RSCD_MAIN_BASE + {4'h0, st.w1.main_divider_code};
      next_st.cp_step    = 4'($signed({1'b0, st.w1.pump_current_trim}) - 4'sh4);
      next_st.pump_hi    = pump_sel_s;
      if (pu_aux_s && pu_osc_s && pu_radio_s && pu_synth_s) begin
         if (rxon_s && txon_s) next_st.mode = rscd_pkg::RSCD_RSSI;
         else if (txon_s) next_st.mode = rscd_pkg::RSCD_TX;
         else if (rxon_s) next_st.mode = rscd_pkg::RSCD_RX;
         else next_st.mode = rscd_pkg::RSCD_IDLE;
      end else begin
         next_st.mode = rscd_pkg::RSCD_IDLE;
      end
      // demod trim only while receive mode is decoded
      next_st.demod_trim = (next_st.mode == rscd_pkg::RSCD_RX) ? st.w2.demod_center_trim : 5'h00;
      tx_mode = pu_radio_s && txon_s && !rxon_s;
      rx_mode = pu_radio_s && rxon_s && !txon_s;
      next_st.dev_pct = tx_mode ? rscd_pct(st.w1.deviation_scale) : 8'h00;
      next_st.mcc_pct = tx_mode ? rscd_pct(st.w2.mod_comp_scale) : 8'h00;
      next_st.en.aux_reg         = pu_aux_s;
      next_st.en.osc_reg         = pu_osc_s;
      next_st.en.program_divider = pu_synth_s;
      next_st.en.phase_compare   = pu_synth_s;
      next_st.en.charge_pump     = pu_synth_s;
      next_st.en.ref_divider     = pu_synth_s;
      next_st.en.tx_driver = tx_mode;
      next_st.en.ramp_gen  = tx_mode;
      next_st.en.tx_switch = tx_mode;
      // receive chain, signal-strength-only keeps mixer and amps
      next_st.en.baseband_filter = rx_mode;
      next_st.en.demod           = rx_mode;
      next_st.en.if_amp          = pu_radio_s && rxon_s;
      next_st.en.ir_mixer        = pu_radio_s && rxon_s;
      next_st.en.rx_switch       = pu_radio_s && rxon_s;
      next_st.en.gauss_filter = tx_mode && st.w1.gauss_filter_enable;
      next_st.en.mod_comp     = tx_mode && st.w1.mod_comp_enable;
      // test dividers: halve reference and program divider, reference/512
      if (ref_div_out && !st.ref_d) begin
         next_st.ref_half = !st.ref_half;
         next_st.ref_cnt  = st.ref_cnt + 1'b1;
      end
      if (prog_div_out && !st.prog_d) next_st.prog_half = !st.prog_half;
      next_st.pump_z = st.w2.test_select[2];
      case (st.w2.test_select[1:0])
         2'h0:    next_st.lock_pin = st.w1.test_bit ? lock_s : 1'b0;
         2'h1:    next_st.lock_pin = !st.w1.test_bit ? st.ref_half : 1'b0;
         2'h2:    next_st.lock_pin = st.w1.test_bit ? st.prog_half : 1'b0;
         default: next_st.lock_pin = st.w2.test_select[2] ? st.ref_d : st.ref_cnt[`RSCD_TDIV_W-1];
      endcase
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) st <= '0;
      else st <= next_st;
   end
   // outputs straight from state
   assign channel_setup_word   = st.w1;
   assign production_trim_word = st.w2;
   assign ref_ratio            = st.ref_ratio;
   assign main_ratio           = st.main_ratio;
   assign swallow_count        = st.w1.swallow_count;
   assign osc_select           = st.w1.osc_select;
   assign deviation_pct        = st.dev_pct;
   assign mod_comp_pct         = st.mcc_pct;
   assign osc_pretune_code     = st.w1.osc_pretune_code;
   assign pump_current_step    = st.cp_step;
   assign demod_center_trim    = st.demod_trim;
   assign pump_high_current    = st.pump_hi;
   assign pump_high_z          = st.pump_z;
   assign enables              = st.en;
   assign mode                 = st.mode;
   assign lock_indicator       = st.lock_pin;
   // assertions on capture, latch and decode
   // shift sequence: rising clock while enable low
   sequence rscd_rise_s;
      !sen_s && sclk_s && !st.sclk_d && st.sst == rscd_pkg::RSCD_SHIFT;
   endsequence
   AST_SHIFT: assert property (@(posedge clk) disable iff (reset)
      rscd_rise_s |=> st.shreg[0] == $past(sdat_s)) else $error("bit not shifted in");
   // latch checks: the address bit picks the target
   AST_LATCH1: assert property (@(posedge clk) disable iff (reset)
      (st.sst == rscd_pkg::RSCD_SHIFT && sen_s && st.shreg[0]) |=> st.w1 == $past(st.shreg[W1_LEN:1]))
      else $error("word one not latched");
   AST_LATCH2: assert property (@(posedge clk) disable iff (reset)
      (st.sst == rscd_pkg::RSCD_SHIFT && sen_s && !st.shreg[0]) |=> st.w2 == $past(st.shreg[W2_LEN:1]))
      else $error("word two not latched");
   AST_HOLD: assert property (@(posedge clk) disable iff (reset)
      !sen_s |=> $stable(st.w1) && $stable(st.w2)) else $error("latch changed while enable low");
   // decode checks, one cycle behind the latch
   AST_REF: assert property (@(posedge clk) disable iff (reset)
      st.w1.ref_divider_code == 2'h2 ##1 st.w1.ref_divider_code == 2'h2 |-> ref_ratio == 4'h6)
      else $error("reference ratio wrong");
   AST_MAIN: assert property (@(posedge clk) disable iff (reset)
      $stable(st.w1) |=> main_ratio == 6'($past(st.w1.main_divider_code) + 6'h20))
      else $error("main ratio wrong");
   AST_TRIM: assert property (@(posedge clk) disable iff (reset)
      $stable(st.w1) |=> pump_current_step == 4'($past(st.w1.pump_current_trim) - 3'h4))
      else $error("pump trim wrong");
   // mode pin decode and pump high impedance checks
   AST_RSSI: assert property (@(posedge clk) disable iff (reset)
      (rxon_s && txon_s && pu_radio_s) |=> enables.if_amp && !enables.demod && !enables.tx_driver)
      else $error("signal strength mode wrong");
   AST_TXEN: assert property (@(posedge clk) disable iff (reset)
      (txon_s && !rxon_s && pu_radio_s) |=> enables.tx_driver && enables.ramp_gen)
      else $error("transmit blocks off");
   AST_HIZ: assert property (@(posedge clk) disable iff (reset)
      $stable(st.w2) ##1 $stable(st.w2) |-> pump_high_z == st.w2.test_select[2])
      else $error("pump high impedance wrong");
   // lock status selected: test code zero with the test bit set
   sequence rscd_locksel_s;
      st.w2.test_select[1:0] == 2'h0 && st.w1.test_bit;
   endsequence
   AST_LOCK: assert property (@(posedge clk) disable iff (reset)
      rscd_locksel_s |=> lock_indicator == $past(lock_s)) else $error("lock status not shown");
   AST_DEMOD: assert property (@(posedge clk) disable iff (reset)
      mode != rscd_pkg::RSCD_RX |-> demod_center_trim == 5'h00) else $error("demod trim outside receive");
   AST_TXONLY: assert property (@(posedge clk) disable iff (reset)
      !(txon_s && !rxon_s && pu_radio_s) |=> !enables.gauss_filter && !enables.mod_comp)
      else $error("filter or compensation outside transmit");
   AST_START: assert property (@(posedge clk) disable iff (reset)
      (st.sst == rscd_pkg::RSCD_WAIT && !st.sen_d) |=> st.sst == rscd_pkg::RSCD_WAIT)
      else $error("frame opened without enable fall");
endmodule : rscd_top

/* File: testbench/rscd_ctrl_model.sv */
// baseband controller model that drives the three-wire programming bus
`timescale 1ns/1ps
module rscd_ctrl_model #(
   parameter int HALF_NS = 24,  // half period of the bus clock
   parameter int GAP_NS  = 260  // idle time after each transfer
) (
   // three-wire bus outputs
   output logic bus_clock,
   output logic bus_data,
   output logic bus_enable
);
   // idle bus: enable high, clock parked low between frames
   initial begin
      bus_clock  = 1'b0;
      bus_data   = 1'b0;
      bus_enable = 1'b1;
   end
   // send the n low bits of a vector, msb first, address bit last
   task automatic send(input logic [31:0] bits, input int n);
      bus_enable = 1'b0;
      #(HALF_NS);
      for (int i = n - 1; i >= 0; i--) begin
         bus_data = bits[i];
         #(HALF_NS);
         bus_clock = 1'b1;
         #(HALF_NS);
         bus_clock = 1'b0;
      end
      #(HALF_NS);
      bus_enable = 1'b1;
      // a released data line must not keep its last value
      bus_data = ~bus_data;
      #(GAP_NS);
   endtask : send
endmodule : rscd_ctrl_model

/* File: testbench/rscd_top_test.sv */
// self-checking bench for the serial control decode block
`timescale 1ns/1ps
module rscd_top_test;
   // clock, reset and pins
   logic clk;
   logic reset;
   logic bus_clock, bus_data, bus_enable;
   logic rx_on, tx_on, synth_locked, ref_div_out, prog_div_out, pump_current_select;
   logic aux_regulator_powerup, osc_regulator_powerup, radio_path_powerup, synth_powerup;
   // design outputs
   rscd_pkg::rscd_word1_t   channel_setup_word;
   rscd_pkg::rscd_word2_t   production_trim_word;
   rscd_pkg::rscd_enables_t enables;
   rscd_pkg::rscd_mode_t    mode;
   logic [3:0]              ref_ratio;
   logic [5:0]              main_ratio;
   logic [4:0]              swallow_count, demod_center_trim;
   logic [7:0]              deviation_pct, mod_comp_pct;
   logic [2:0]              osc_pretune_code;
   logic signed [3:0]       pump_current_step;
   logic                    osc_select, pump_high_current, pump_high_z, lock_indicator;
   // bookkeeping and expected tables
   int                      fails;
   int                      tests_run;
   int                      refs;       // reference divider rising edges sent
   logic                    v0;         // lock pin level before a pulse
   logic [3:0]              rtab [4];
   rscd_pkg::rscd_word1_t   w1;
   rscd_pkg::rscd_word2_t   w2;

   // design and controller model
   rscd_top u_rscd_top (.*);
   rscd_ctrl_model u_rscd_ctrl_model (.bus_clock(bus_clock), .bus_data(bus_data), .bus_enable(bus_enable));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // compare and count
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   // wait a number of falling edges
   task automatic wclk(input int n);
      repeat (n) @(negedge clk);
   endtask : wclk

   // pulse one divider input n times at falling edges, then let the decode settle
   task automatic pulse(input logic prog, input int n);
      repeat (n) begin
         @(negedge clk);
         if (prog) prog_div_out <= 1'b1;
         else ref_div_out <= 1'b1;
         @(negedge clk);
         prog_div_out <= 1'b0;
         ref_div_out <= 1'b0;
         if (!prog) refs++;
      end
      wclk(2);
   endtask : pulse

   // load both words, address 1 for word one, 0 for word two
   task automatic load(input rscd_pkg::rscd_word1_t a, input rscd_pkg::rscd_word2_t b);
      u_rscd_ctrl_model.send({8'h00, a, 1'b1}, 24);
      u_rscd_ctrl_model.send({20'hFFFFF, b, 1'b0}, 12);
      wclk(12);
   endtask : load

   // set mode pins at a falling edge and let the synchroniser settle
   task automatic pins(input logic rx, input logic tx, input logic pu);
      @(negedge clk);
      rx_on <= rx;
      tx_on <= tx;
      synth_powerup <= pu;
      wclk(10);
   endtask : pins

   // both latched words clear and mode idle after reset
   task automatic t_reset;
      chk("word1", 32'h0, channel_setup_word);
      chk("word2", 32'h0, production_trim_word);
      chk("mode", rscd_pkg::RSCD_IDLE, mode);
      wclk(10);
   endtask : t_reset

   // reset in mid-run clears both loaded latches
   task automatic t_rerun;
      @(negedge clk);
      reset = 1'b1;
      wclk(2);
      reset = 1'b0;
      wclk(2);
      t_reset();
   endtask : t_rerun

   // every divider code and the ratio, swallow, oscillator, pretune and pump decodes of word one
   task automatic t_word1;
      for (int i = 0; i < 4; i++) begin
         w1 = {2'(i), 5'(i * 10 + 1), 2'(i), 1'(i), 1'b0, 1'b1, 1'b1, 1'b0, 3'(i + 4), 3'(i), 3'(i * 2 + 1)};
         u_rscd_ctrl_model.send({8'h00, w1, 1'b1}, 24);
         wclk(12);
         chk("word1", 32'(w1), channel_setup_word);
         chk("ref_ratio", 32'(rtab[i]), ref_ratio);
         chk("main_ratio", 32'(32 + i), main_ratio);
         chk("swallow", 32'(i * 10 + 1), swallow_count);
         chk("osc_select", 32'(i % 2), osc_select);
         chk("pretune", 32'(i), osc_pretune_code);
         chk("pump_step", {28'h0, 4'(i * 2 + 1) - 4'h4}, {28'h0, pump_current_step});
      end
   endtask : t_word1

   // word two after long leading junk, word one untouched
   task automatic t_word2;
      w2 = {5'h15, 3'h2, 3'h0};
      u_rscd_ctrl_model.send({20'hFFFFF, w2, 1'b0}, 32);
      wclk(12);
      chk("word2", 32'(w2), production_trim_word);
      chk("word1 kept", 32'(w1), channel_setup_word);
   endtask : t_word2

   // transmit, receive, signal-strength and synthesizer power modes
   task automatic t_modes;
      pump_current_select <= 1'b1;
      pins(1'b0, 1'b1, 1'b1);
      chk("pump high", 32'h1, pump_high_current);
      chk("mode tx", rscd_pkg::RSCD_TX, mode);
      chk("tx driver", 32'h1, enables.tx_driver);
      chk("ramp", 32'h1, enables.ramp_gen);
      chk("gauss", 32'h1, enables.gauss_filter);
      chk("comp", 32'h0, enables.mod_comp);
      chk("deviation", 32'd130, deviation_pct);
      chk("comp pct", 32'd80, mod_comp_pct);
      chk("demod tx", 32'h0, demod_center_trim);
      pins(1'b1, 1'b0, 1'b1);
      chk("mode rx", rscd_pkg::RSCD_RX, mode);
      chk("bb filter", 32'h1, enables.baseband_filter);
      chk("demod trim", 32'h15, demod_center_trim);
      chk("deviation rx", 32'h0, deviation_pct);
      chk("gauss rx", 32'h0, enables.gauss_filter);
      pins(1'b1, 1'b1, 1'b1);
      chk("mode rssi", rscd_pkg::RSCD_RSSI, mode);
      chk("if amp", 32'h1, enables.if_amp);
      chk("bb rssi", 32'h0, {enables.baseband_filter, enables.demod, enables.tx_driver});
      chk("pll on", 32'hF, {enables.program_divider, enables.phase_compare, enables.charge_pump,
                             enables.ref_divider});
      pins(1'b1, 1'b1, 1'b0);
      chk("pll off", 32'h0, {enables.program_divider, enables.charge_pump, enables.ref_divider});
   endtask : t_modes

   // lock pin selections and charge pump high impedance
   task automatic t_lock;
      for (int k = 0; k < 2; k++) begin
         w2.test_select = 3'(k * 4);
         load(w1, w2);
         @(negedge clk);
         synth_locked <= 1'b1;
         wclk(8);
         chk("lock high", 32'h1, lock_indicator);
         chk("high z", 32'(k), pump_high_z);
         synth_locked <= 1'b0;
         wclk(8);
         chk("lock low", 32'h0, lock_indicator);
      end
      w2.test_select = 3'h7;
      load(w1, w2);
      for (int k = 0; k < 7; k++) begin
         ref_div_out <= k[0];
         refs += k[0];
         wclk(2);
         chk("raw ref", 32'(k[0]), lock_indicator);
      end
   endtask : t_lock

   // remaining lock pin tests: reference/512, halved reference, halved program divider
   task automatic t_test;
      w2.test_select = 3'h3;
      load(w1, w2);
      chk("ref 512 low", 32'(refs[8]), lock_indicator);
      pulse(1'b0, 256 - refs % 256);
      chk("ref 512 high", 32'(refs[8]), lock_indicator);
      for (int k = 0; k < 2; k++) begin
         w1.test_bit = k[0];
         w2.test_select = 3'(k + 1);
         load(w1, w2);
         v0 = lock_indicator;
         pulse(k[0], 1);
         chk("half toggle", 32'(!v0), lock_indicator);
         pulse(k[0], 1);
         chk("half return", 32'(v0), lock_indicator);
      end
   endtask : t_test

   // verdict and end of run
   task automatic stop_test;
      if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // watchdog against a hang
   initial begin
      #200000;
      fails++;
      stop_test();
   end

   // main sequence
   initial begin
      fails = 0;
      tests_run = 0;
      refs = 0;
      rtab = '{4'h3, 4'h4, 4'h6, 4'h0};
      reset = 1'b1;
      {rx_on, tx_on, synth_locked, ref_div_out, prog_div_out, pump_current_select} = 6'h00;
      {aux_regulator_powerup, osc_regulator_powerup, radio_path_powerup, synth_powerup} = 4'hF;
      wclk(10);
      reset = 1'b0;
      wclk(2);
      t_reset();
      t_word1();
      t_word2();
      t_modes();
      t_lock();
      t_test();
      t_rerun();
      stop_test();
   end
endmodule : rscd_top_test
